// >>> hvw_wake_monitor.sv
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - three wake pins, each with own logic
// - rising and falling edges both signal events
// - interrupt in normal/stop, wake in sleep/fail-safe
// - static sense keeps detection always active
// - cyclic sense evaluates only in timer on-time
// - event only if stable for whole filter
// - code 00 short static, 01 long static
// - code 10 cyclic on first timer, short
// - code 11 cyclic on second timer, short
// - per-pin wake enable bits in control register
// - per-pin wake source flags, always readable
// - level register shows live pin levels
// - levels reported even when wake disabled
// - cyclic sense reports last sampled level
// - fail outputs: fixed short filter, status b
// - pull code 00 no source, reset default
// - pull code 01 enables pull-down
// - pull code 10 enables pull-up
// - pull code 11 follows detected level
//
// The APB interface to the registers and the register addresses were decided locally.
module hvw_wake_monitor
  import hvw_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // comparator outputs of the high-voltage pins
  input wire logic [2:0] i_hv_wake_pin,
  input wire logic i_fail_output_two,
  input wire logic i_fail_output_three,
  // on-time windows of the two cyclic sense timers
  input wire logic i_first_timer_on,
  input wire logic i_second_timer_on,
  // current source controls per wake pin
  output logic [2:0] o_pull_up_en,
  output logic [2:0] o_pull_down_en,
  // event signalling
  output logic o_irq,
  output logic o_wake_req
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // filter length in cycles minus one for a filter field code
  function automatic logic [HVW_CNT_W-1:0] filt_last(input logic [1:0] code);
    if (code == HVW_FLT_STATIC_LONG) begin
      filt_last = HVW_LONG_FILTER_CYC - HVW_CNT_W'(1);
    end else begin
      // every other code, cyclic included, uses the short filter
      filt_last = HVW_SHORT_FILTER_CYC - HVW_CNT_W'(1);
    end
  endfunction

  // cyclic sense codes have the top filter bit set
  function automatic logic is_cyclic(input logic [1:0] code);
    is_cyclic = code[1];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [2:0] wake_en_r; // wake enable per wake pin
  logic [5:0] pull_r; // two pull bits per wake pin
  logic [5:0] filter_r; // two filter bits per wake pin
  logic [3:0] mode_ctrl_r; // power mode and fail output wake config
  logic [2:0] src_a_r; // sticky wake source flags, wake pins
  logic [1:0] src_b_r; // sticky wake source flags, fail outputs
  logic [2:0] level_r; // reported pin levels
  logic [31:0] prdata_r; // read data captured in the setup cycle
  logic irq_r; // interrupt pulse
  logic wake_r; // wake request pulse
  logic [2:0] pu_r; // pull-up enables
  logic [2:0] pd_r; // pull-down enables

  logic [HVW_NUM_CHAN-1:0] sync1_r; // first synchroniser stage
  logic [HVW_NUM_CHAN-1:0] sync2_r; // second synchroniser stage
  logic [HVW_NUM_CHAN-1:0] stable_r; // last accepted level per channel
  logic [HVW_CNT_W-1:0] cnt_r [HVW_NUM_CHAN]; // filter counters

  // decoded per-channel view
  hvw_pin_cfg_t cfg [HVW_NUM_CHAN];
  logic [HVW_NUM_CHAN-1:0] chan_active; // channel may be evaluated now
  logic [HVW_NUM_CHAN-1:0] chan_event; // filtered edge this cycle
  logic [HVW_NUM_CHAN-1:0] chan_flag; // events that count as wake sources
  hvw_mode_t mode;
  logic [HVW_NUM_CHAN-1:0] raw_in;

  // apb decode
  logic wr_en;
  logic setup;
  logic addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign mode = hvw_mode_t'(mode_ctrl_r[HVW_MODE_POS +: 2]);
  assign raw_in = {i_fail_output_three, i_fail_output_two, i_hv_wake_pin};

  // map check for the offset being accessed
  always_comb begin
    case (i_paddr)
      HVW_WAKE_ENABLE_CONTROL_OFS,
      HVW_PULL_SOURCE_CONTROL_OFS,
      HVW_FILTER_MODE_CONTROL_OFS,
      HVW_WAKE_SOURCE_STATUS_A_OFS,
      HVW_WAKE_SOURCE_STATUS_B_OFS,
      HVW_PIN_LEVEL_STATUS_OFS,
      HVW_MODE_CONTROL_OFS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // zero wait states: read data was already taken in the setup cycle
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // channel configuration

  // wake pins follow their fields, fail outputs are fixed short static
  always_comb begin
    for (int i = 0; i < HVW_NUM_CHAN; i++) begin
      if (i < HVW_NUM_WAKE) begin
        cfg[i].pull = pull_r[i*HVW_FIELD_W +: 2];
        cfg[i].filter = filter_r[i*HVW_FIELD_W +: 2];
      end else begin
        cfg[i].pull = HVW_PULL_NONE;
        cfg[i].filter = HVW_FLT_STATIC_SHORT;
      end
    end
  end

  // sense window per channel
  always_comb begin
    for (int i = 0; i < HVW_NUM_CHAN; i++) begin
      if (i >= HVW_NUM_WAKE) begin
        // fail outputs only watched when configured as wake inputs
        chan_active[i] = mode_ctrl_r[HVW_FO_CFG_POS + i - HVW_NUM_WAKE];
      end else begin
        case (cfg[i].filter)
          HVW_FLT_CYCLIC_T1: chan_active[i] = i_first_timer_on;
          HVW_FLT_CYCLIC_T2: chan_active[i] = i_second_timer_on;
          default: chan_active[i] = 1'b1;
        endcase
      end
    end
  end

  // an event fires when a changed level outlasts the filter
  always_comb begin
    for (int i = 0; i < HVW_NUM_CHAN; i++) begin
      // either direction of change counts the same way
      chan_event[i] = chan_active[i] && (sync2_r[i] != stable_r[i]) &&
        (cnt_r[i] >= filt_last(cfg[i].filter));
      if (i < HVW_NUM_WAKE) begin
        chan_flag[i] = chan_event[i] && wake_en_r[i];
      end else begin
        chan_flag[i] = chan_event[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchroniser

  // comparators are asynchronous to the clock, so two stages first
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // filters

  // counter runs while the synchronised level differs from the accepted one
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      stable_r <= '0;
      for (int i = 0; i < HVW_NUM_CHAN; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < HVW_NUM_CHAN; i++) begin
        if (!chan_active[i]) begin
          // outside the window nothing is evaluated; pending work dropped
          cnt_r[i] <= '0;
        end else if (sync2_r[i] == stable_r[i]) begin
          // crossing back before the filter expired abandons the event
          cnt_r[i] <= '0;
        end else if (chan_event[i]) begin
          stable_r[i] <= sync2_r[i];
          cnt_r[i] <= '0;
        end else begin
          cnt_r[i] <= cnt_r[i] + HVW_CNT_W'(1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // level reporting

  // disabled pins still report; cyclic pins hold their last sample
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      level_r <= '0;
    end else begin
      for (int i = 0; i < HVW_NUM_WAKE; i++) begin
        if (!is_cyclic(cfg[i].filter)) begin
          level_r[i] <= sync2_r[i];
        end else if (chan_active[i]) begin
          level_r[i] <= sync2_r[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pull sources

  // auto mode tracks the synchronised level, giving a latch-like hold
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pu_r <= '0;
      pd_r <= '0;
    end else begin
      for (int i = 0; i < HVW_NUM_WAKE; i++) begin
        case (cfg[i].pull)
          HVW_PULL_DOWN: begin
            pu_r[i] <= 1'b0;
            pd_r[i] <= 1'b1;
          end
          HVW_PULL_UP: begin
            pu_r[i] <= 1'b1;
            pd_r[i] <= 1'b0;
          end
          HVW_PULL_AUTO: begin
            pu_r[i] <= sync2_r[i];
            pd_r[i] <= !sync2_r[i];
          end
          default: begin
            // floating pin relies on board ties
            pu_r[i] <= 1'b0;
            pd_r[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  assign o_pull_up_en = pu_r;
  assign o_pull_down_en = pd_r;

  ////////////////////////////////////////////////////////////////////////////
  // event signalling

  // mode picks interrupt or wake; both are one-cycle pulses
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      case (mode)
        HVW_NORMAL_MODE, HVW_STOP_MODE: begin
          irq_r <= |chan_flag;
          wake_r <= 1'b0;
        end
        HVW_SLEEP_MODE, HVW_FAIL_SAFE_MODE: begin
          irq_r <= 1'b0;
          wake_r <= |chan_flag;
        end
        default: begin
          irq_r <= 1'b0;
          wake_r <= 1'b0;
        end
      endcase
    end
  end

  assign o_irq = irq_r;
  assign o_wake_req = wake_r;

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  // writes land at the access edge; pready is always high
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wake_en_r <= HVW_WAKE_EN_RST;
      pull_r <= HVW_PULL_RST;
      filter_r <= HVW_FILTER_RST;
      mode_ctrl_r <= HVW_MODE_CTRL_RST;
    end else if (wr_en) begin
      case (i_paddr)
        HVW_WAKE_ENABLE_CONTROL_OFS: wake_en_r <= i_pwdata[2:0];
        HVW_PULL_SOURCE_CONTROL_OFS: pull_r <= i_pwdata[5:0];
        HVW_FILTER_MODE_CONTROL_OFS: filter_r <= i_pwdata[5:0];
        HVW_MODE_CONTROL_OFS: mode_ctrl_r <= i_pwdata[3:0];
        default: begin
          // status, level and unmapped writes change nothing here
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake source flags

  // write one to clear; a new event in the clearing cycle wins
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      src_a_r <= '0;
      src_b_r <= '0;
    end else begin
      if (wr_en && i_paddr == HVW_WAKE_SOURCE_STATUS_A_OFS) begin
        src_a_r <= (src_a_r & ~i_pwdata[2:0]) | chan_flag[2:0];
      end else begin
        src_a_r <= src_a_r | chan_flag[2:0];
      end
      if (wr_en && i_paddr == HVW_WAKE_SOURCE_STATUS_B_OFS) begin
        src_b_r <= (src_b_r & ~i_pwdata[1:0]) | chan_flag[4:3];
      end else begin
        src_b_r <= src_b_r | chan_flag[4:3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  // captured in the setup cycle so the access phase sees a flop output
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      prdata_r <= '0;
    end else if (setup) begin
      case (i_paddr)
        HVW_WAKE_ENABLE_CONTROL_OFS: prdata_r <= {29'h0, wake_en_r};
        HVW_PULL_SOURCE_CONTROL_OFS: prdata_r <= {26'h0, pull_r};
        HVW_FILTER_MODE_CONTROL_OFS: prdata_r <= {26'h0, filter_r};
        HVW_WAKE_SOURCE_STATUS_A_OFS: prdata_r <= {29'h0, src_a_r};
        HVW_WAKE_SOURCE_STATUS_B_OFS: prdata_r <= {30'h0, src_b_r};
        HVW_PIN_LEVEL_STATUS_OFS: prdata_r <= {29'h0, level_r};
        HVW_MODE_CONTROL_OFS: prdata_r <= {28'h0, mode_ctrl_r};
        default: prdata_r <= '0;
      endcase
    end
  end

  assign o_prdata = prdata_r;

endmodule // hvw_wake_monitor

// >>> hvw_pkg.sv
package hvw_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] HVW_WAKE_ENABLE_CONTROL_OFS = 8'h00;
  localparam logic [7:0] HVW_PULL_SOURCE_CONTROL_OFS = 8'h04;
  localparam logic [7:0] HVW_FILTER_MODE_CONTROL_OFS = 8'h08;
  localparam logic [7:0] HVW_WAKE_SOURCE_STATUS_A_OFS = 8'h0c;
  localparam logic [7:0] HVW_WAKE_SOURCE_STATUS_B_OFS = 8'h10;
  localparam logic [7:0] HVW_PIN_LEVEL_STATUS_OFS = 8'h14;
  localparam logic [7:0] HVW_MODE_CONTROL_OFS = 8'h18;

  // field positions
  localparam int HVW_MODE_POS = 0;     // power mode, 2 bits
  localparam int HVW_FO_CFG_POS = 2;   // fail outputs as wake inputs, 2 bits
  localparam int HVW_FIELD_W = 2;      // pull and filter field width per pin

  // reset values
  localparam logic [2:0] HVW_WAKE_EN_RST = 3'h0;
  localparam logic [5:0] HVW_PULL_RST = 6'h00;
  localparam logic [5:0] HVW_FILTER_RST = 6'h00;
  localparam logic [3:0] HVW_MODE_CTRL_RST = 4'h0;

  // pin channel counts: three wake pins plus two fail outputs
  localparam int HVW_NUM_WAKE = 3;
  localparam int HVW_NUM_CHAN = 5;

  // pull field codes
  localparam logic [1:0] HVW_PULL_NONE = 2'h0;
  localparam logic [1:0] HVW_PULL_DOWN = 2'h1;
  localparam logic [1:0] HVW_PULL_UP = 2'h2;
  localparam logic [1:0] HVW_PULL_AUTO = 2'h3;

  // filter field codes
  localparam logic [1:0] HVW_FLT_STATIC_SHORT = 2'h0;
  localparam logic [1:0] HVW_FLT_STATIC_LONG = 2'h1;
  localparam logic [1:0] HVW_FLT_CYCLIC_T1 = 2'h2;
  localparam logic [1:0] HVW_FLT_CYCLIC_T2 = 2'h3;

  // filter timing
  localparam int HVW_CLK_PERIOD_NS = 25;
  localparam int HVW_SHORT_FILTER_TIME_NS = 16000;
  localparam int HVW_LONG_FILTER_TIME_NS = 64000;
  localparam int HVW_CNT_W = 12;
  localparam logic [HVW_CNT_W-1:0] HVW_SHORT_FILTER_CYC =
    HVW_CNT_W'((HVW_SHORT_FILTER_TIME_NS + HVW_CLK_PERIOD_NS - 1)
               / HVW_CLK_PERIOD_NS);
  localparam logic [HVW_CNT_W-1:0] HVW_LONG_FILTER_CYC =
    HVW_CNT_W'((HVW_LONG_FILTER_TIME_NS + HVW_CLK_PERIOD_NS - 1)
               / HVW_CLK_PERIOD_NS);

  // device power modes
  typedef enum logic [1:0] {
    HVW_NORMAL_MODE,
    HVW_STOP_MODE,
    HVW_SLEEP_MODE,
    HVW_FAIL_SAFE_MODE
  } hvw_mode_t;

  // per-pin configuration as decoded from the control registers
  typedef struct packed {
    logic [1:0] pull;
    logic [1:0] filter;
  } hvw_pin_cfg_t;

endpackage

// >>> hvw_wake_monitor_asserts.sv
module hvw_wake_monitor_asserts
  import hvw_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [2:0] i_hv_wake_pin,
  input wire logic i_fail_output_two,
  input wire logic i_fail_output_three,
  input wire logic i_first_timer_on,
  input wire logic i_second_timer_on,
  input wire logic [2:0] o_pull_up_en,
  input wire logic [2:0] o_pull_down_en,
  input wire logic o_irq,
  input wire logic o_wake_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // a little below the 640-cycle filter: sync stages blur the start
  localparam logic [11:0] MIN_STABLE = 12'h276;
  logic [4:0] chan;
  logic [4:0] chan_r;
  logic [11:0] stab_r [5];
  logic [4:0] settled;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  //////////////////////////////////////////////////////////////////////////
  // cycles since each input last moved, saturating
  assign chan = {i_fail_output_three, i_fail_output_two, i_hv_wake_pin};
  always_ff @(posedge i_sys_clk) begin
    chan_r <= chan;
  end
  always_ff @(posedge i_sys_clk) begin
    for (int k = 0; k < 5; k++) begin
      if (i_rst || chan[k] != chan_r[k]) begin
        stab_r[k] <= 12'h0;
      end else if (stab_r[k] != 12'hfff) begin
        stab_r[k] <= stab_r[k] + 12'h1;
      end
    end
  end
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      settled[k] = stab_r[k] >= MIN_STABLE;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  chk_pready_high: assert property (o_pready)
    else $error("pready low");
  chk_bad_addr: assert property (i_psel && i_penable &&
    i_paddr > 8'h18 |-> o_pslverr && o_prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_good_addr: assert property (i_psel && i_penable &&
    i_paddr <= 8'h18 && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
    else $error("mapped access refused");
  chk_err_phase: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("pslverr outside access");
  chk_rdata_hold: assert property (!(i_psel && !i_penable)
    |=> $stable(o_prdata)) else $error("read data moved");
  chk_event_excl: assert property (!(o_irq && o_wake_req))
    else $error("irq and wake together");
  chk_event_filter: assert property (o_irq || o_wake_req
    |-> |settled) else $error("event without stable input");
  chk_reset_quiet: assert property ($fell(i_rst) |-> !o_irq &&
    !o_wake_req && o_pull_up_en == 3'h0 && o_pull_down_en == 3'h0)
    else $error("outputs active after reset");
  chk_pull_excl: assert property ((o_pull_up_en & o_pull_down_en)
    == 3'h0) else $error("both pulls on");
endmodule // hvw_wake_monitor_asserts

bind hvw_wake_monitor hvw_wake_monitor_asserts u_chk (.i_sys_clk, .i_rst,
  .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
  .o_pslverr, .i_hv_wake_pin, .i_fail_output_two, .i_fail_output_three,
  .i_first_timer_on, .i_second_timer_on, .o_pull_up_en, .o_pull_down_en,
  .o_irq, .o_wake_req);

// >>> hvw_pin_model.sv
// external switches on the wake pins, with the chip's current sources
module hvw_pin_model (
  input wire logic i_sys_clk,
  input wire logic [2:0] i_drv,  // switch level per pin
  input wire logic [2:0] i_conn, // switch connected per pin
  input wire logic [2:0] i_pu,
  input wire logic [2:0] i_pd,
  output logic [2:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // an open pin with no source wanders, so it toggles every cycle
  always_ff @(posedge i_sys_clk) begin
    for (int k = 0; k < 3; k++) begin
      if (i_conn[k]) begin
        o_pin[k] <= i_drv[k];
      end else if (i_pu[k]) begin
        o_pin[k] <= 1'b1;
      end else if (i_pd[k]) begin
        o_pin[k] <= 1'b0;
      end else begin
        o_pin[k] <= ~o_pin[k];
      end
    end
  end
endmodule // hvw_pin_model

// >>> hvw_wake_monitor_tb.sv
module hvw_wake_monitor_tb;
  import hvw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk, i_rst, i_psel, i_penable, i_pwrite;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic o_pready, o_pslverr, o_irq, o_wake_req;
  logic [2:0] i_hv_wake_pin, o_pull_up_en, o_pull_down_en, drv, conn;
  logic i_fail_output_two, i_fail_output_three;
  logic i_first_timer_on, i_second_timer_on;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int nirq = 0;
  int nwk = 0;
  int ei, ew;
  logic [31:0] expq [$]; // expected read data, oldest first
  //////////////////////////////////////////////////////////////////////////
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  hvw_wake_monitor DUT (.i_sys_clk, .i_rst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_hv_wake_pin,
    .i_fail_output_two, .i_fail_output_three, .i_first_timer_on,
    .i_second_timer_on, .o_pull_up_en, .o_pull_down_en, .o_irq, .o_wake_req);
  hvw_pin_model u_pins (.i_sys_clk, .i_drv(drv), .i_conn(conn),
    .i_pu(o_pull_up_en), .i_pd(o_pull_down_en), .o_pin(i_hv_wake_pin));
  //////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  // one apb transfer; request held until pready is seen
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    @(posedge i_sys_clk);
    while (o_pready !== 1'b1) @(posedge i_sys_clk);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // watcher: event counts, read checks and the hang limit
  always @(posedge i_sys_clk) begin
    cyc++;
    if (o_irq === 1'b1) nirq++;
    if (o_wake_req === 1'b1) nwk++;
    if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1) begin
      if (expq.size() > 0) chk(o_prdata, expq.pop_front());
    end
    if (cyc == 40000) begin
      mismatches++;
      close_out();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(52));
    i_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h0;
    i_pwdata = 32'h0;
    i_fail_output_two = 1'b0;
    i_fail_output_three = 1'b0;
    i_first_timer_on = 1'b0;
    i_second_timer_on = 1'b0;
    drv = 3'h0;
    conn = 3'h7; // pins tied by switches, never left floating
    wt(4);
    i_rst <= 1'b0;
    wt(10);
    for (int a = 0; a < 32; a += 4) rd(8'(a), 32'h0);
    wr(8'h20, $urandom());
    wr(HVW_WAKE_ENABLE_CONTROL_OFS, 32'h7);
    wr(HVW_PULL_SOURCE_CONTROL_OFS, 32'h39);
    wt(5);
    chk(32'(o_pull_down_en), 32'h5);
    chk(32'(o_pull_up_en), 32'h2);
    drv[2] <= 1'b1;
    wt(700);
    chk(32'(o_pull_up_en), 32'h6);
    chk(nirq, 1);
    rd(HVW_WAKE_SOURCE_STATUS_A_OFS, 32'h4);
    rd(HVW_PIN_LEVEL_STATUS_OFS, 32'h4);
    wr(HVW_WAKE_SOURCE_STATUS_A_OFS, 32'h7);
    drv[0] <= 1'b1;
    wt($urandom_range(600, 100));
    drv[0] <= 1'b0;
    wt(700);
    chk(nirq, 1);
    drv[2] <= 1'b0;
    wt(700);
    chk(nirq, 2);
    // pin 1 on the long filter: quiet at 1500 cycles, flagged by 2700
    wr(HVW_FILTER_MODE_CONTROL_OFS, 32'h4);
    wr(HVW_WAKE_SOURCE_STATUS_A_OFS, 32'h7);
    drv[1] <= 1'b1;
    wt(1500);
    rd(HVW_WAKE_SOURCE_STATUS_A_OFS, 32'h0);
    wt(1200);
    rd(HVW_WAKE_SOURCE_STATUS_A_OFS, 32'h2);
    wr(HVW_WAKE_ENABLE_CONTROL_OFS, 32'h3);
    drv[2] <= 1'b1;
    wt(700);
    chk(nirq, 3);
    rd(HVW_PIN_LEVEL_STATUS_OFS, 32'h6);
    // pin 0 cyclic: nothing seen until its timer opens
    wr(HVW_WAKE_SOURCE_STATUS_A_OFS, 32'h7);
    wr(HVW_FILTER_MODE_CONTROL_OFS, 32'h6);
    drv[0] <= 1'b1;
    wt(700);
    rd(HVW_PIN_LEVEL_STATUS_OFS, 32'h6);
    rd(HVW_WAKE_SOURCE_STATUS_A_OFS, 32'h0);
    i_first_timer_on <= 1'b1;
    wt(700);
    rd(HVW_WAKE_SOURCE_STATUS_A_OFS, 32'h1);
    rd(HVW_PIN_LEVEL_STATUS_OFS, 32'h7);
    i_first_timer_on <= 1'b0;
    wr(HVW_WAKE_SOURCE_STATUS_A_OFS, 32'h7);
    wr(HVW_FILTER_MODE_CONTROL_OFS, 32'h7);
    drv[0] <= 1'b0;
    i_second_timer_on <= 1'b1;
    wt(700);
    rd(HVW_WAKE_SOURCE_STATUS_A_OFS, 32'h1);
    ei = 5;
    ew = 0;
    // every power mode, events from fail output two
    for (int m = 0; m < 4; m++) begin
      wr(HVW_MODE_CONTROL_OFS, 32'(m) | 32'h4);
      wr(HVW_WAKE_SOURCE_STATUS_B_OFS, 32'h3);
      i_fail_output_two <= ~i_fail_output_two;
      wt(700);
      if (m < 2) ei++;
      else ew++;
      rd(HVW_WAKE_SOURCE_STATUS_B_OFS, 32'h1);
      chk(nirq, ei);
      chk(nwk, ew);
    end
    wt(2);
    close_out();
  end
endmodule // hvw_wake_monitor_tb
